// ### tcc_pkg.sv
// Constants, field layouts and types for the timer channel compare/capture.
// Assumes nothing of its surroundings; every design file imports it whole.
package tcc_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W         = 16;
  localparam int ADDR_W         = 4;
  localparam int LVL_W          = 4;
  localparam int CAP_FIFO_DEPTH = 8;
  localparam int IRQ_SRC_N      = 8;

  // ----------------------------------------------------------------
  // Register offsets (word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNTER  = 4'h0;
  localparam logic [3:0] ADDR_CMP_ONE  = 4'h1;
  localparam logic [3:0] ADDR_CMP_TWO  = 4'h2;
  localparam logic [3:0] ADDR_PRE_ONE  = 4'h3;
  localparam logic [3:0] ADDR_PRE_TWO  = 4'h4;
  localparam logic [3:0] ADDR_CAP_ONE  = 4'h5;
  localparam logic [3:0] ADDR_CAP_TWO  = 4'h6;
  localparam logic [3:0] ADDR_CONTROL  = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h9;
  localparam logic [3:0] ADDR_FIFO_LVL = 4'ha;

  // ----------------------------------------------------------------
  // Control field positions, and the FIFO two field of the FIFO level word
  // ----------------------------------------------------------------
  localparam int COMPARE_LOAD_CTL_ONE_POS  = 0;
  localparam int COMPARE_LOAD_CTL_TWO_POS  = 3;
  localparam int CMODE_POS = 6;
  localparam int CPT1_POS  = 8;
  localparam int CPT2_POS  = 10;
  localparam int SINGLE_CAPTURE_SEL_POS = 12;
  localparam int CAPTURE_FIFO_WATERMARK_POS  = 13;
  localparam int LVL2_POS  = 4;

  // ----------------------------------------------------------------
  // Status and enable bit positions (same layout)
  // ----------------------------------------------------------------
  localparam int ST_ANY_CMP = 0;
  localparam int ST_CMP_ONE = 1;
  localparam int ST_CMP_TWO = 2;
  localparam int ST_OVF     = 3;
  localparam int ST_FALL    = 4;
  localparam int ST_RISE    = 5;
  localparam int ST_CAP_ONE = 6;
  localparam int ST_CAP_TWO = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0]  IRQ_EN_RST = 8'h00;

  // Compare-load codes
  typedef enum logic [2:0] {
    TCC_LD_NEVER    = 3'b000,
    TCC_LD_P1_ON_C1 = 3'b010,
    TCC_LD_P1_ON_C2 = 3'b011,
    TCC_LD_P2_ON_C1 = 3'b100,
    TCC_LD_P2_ON_C2 = 3'b101,
    TCC_LD_CNT_C1   = 3'b110,
    TCC_LD_CNT_C2   = 3'b111
  } tcc_load_code_t;

endpackage

// ### tcc_fifo_if.sv
// Handshake between the channel and one capture FIFO.
// Assumes the owner only pushes or pops while the clock enable is high.
`timescale 1ns/10ps
interface tcc_fifo_if;
  import tcc_pkg::*;
  logic              push;
  logic              pop;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [LVL_W-1:0]  level;
  logic              full;
  logic              empty;
  modport owner (output push, pop, wdata, input rdata, level, full, empty);
  modport store (input push, pop, wdata, output rdata, level, full, empty);
endinterface

// ### tcc_capture_fifo.sv
// Capture FIFO: a small word store with a fill count.
// Assumes push is never made while full nor pop while empty.
`timescale 1ns/10ps
module tcc_capture_fifo import tcc_pkg::*; #(
  parameter int DEPTH = CAP_FIFO_DEPTH
) (
  input  wire logic   sys_clk_in,
  input  wire logic   resetn_in,
  tcc_fifo_if.store   fifo
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0]    LAST = PW'(DEPTH - 1);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  if (DEPTH < 1 || DEPTH > (2 ** LVL_W) - 1) begin : g_bad_depth
    $error("Capture FIFO depth out of range");
  end

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]     wptr;
  logic [PW-1:0]     rptr;
  logic [LVL_W-1:0]  level;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (fifo.push) begin
      mem[wptr] <= fifo.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      wptr  <= '0;
      rptr  <= '0;
      level <= '0;
    end else begin
      if (fifo.push) begin
        wptr <= wrap_inc(wptr);
      end
      if (fifo.pop) begin
        rptr <= wrap_inc(rptr);
      end
      if (fifo.push && !fifo.pop) begin
        level <= level + 1'b1;
      end else if (fifo.pop && !fifo.push) begin
        level <= level - 1'b1;
      end
    end
  end

  assign fifo.rdata = mem[rptr];
  assign fifo.level = level;
  assign fifo.full  = (level == FULL_LVL);
  assign fifo.empty = (level == '0);

  fifo_bound_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (fifo.push && !fifo.pop) |=> level == $past(level) + 1'b1
      && level <= FULL_LVL)
  else $error("Capture FIFO level wrong after push");

endmodule

// ### tcc_channel.sv
// Compare/capture channel: counter, two comparators with preload,
// two capture paths with FIFOs, sticky status and interrupt request.
// Assumes synchronous pins and a single-cycle strobe register port.
//
// Functional notes
// - Load code 000 never reloads comparator one.
// - Codes 010/011 load comparator one from preload one on match 1/2.
// - Codes 100/101 load comparator one from preload two on match 1/2.
// - Codes 110/111 load counter from preload one on match 1/2.
// - Second load field drives comparator two; 101 loads it from preload two.
// - Capture modes: 00 off, 01 falling, 10 rising, 11 any edge.
// - Counter and both comparators hold any 16-bit value from software.
// - Eight interrupt sources each have their own enable bit.
// - A 16-bit status register shows which channel events occurred.
// - Each capture path has an eight-word FIFO with a fill count.
// - Live counter value is readable any time without disturbing it.
// - Compare mode picks counting direction in which each comparator acts.
// - One-shot setting: 0 free-running capture, 1 single capture.
// - Watermark 0 to 3 sets fill level that flags a capture event.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module tcc_channel import tcc_pkg::*; #(
  parameter int FIFO_DEPTH = CAP_FIFO_DEPTH
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              cnt_tick_in,
  input  wire logic              cnt_down_in,
  input  wire logic              capture_one_in,
  input  wire logic              capture_two_in,
  output logic                   irq_out
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > (2 ** LVL_W) - 1) begin : g_bad_depth
    $error("Channel FIFO depth out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]    counter;
  logic [DATA_W-1:0]    comparator_one;
  logic [DATA_W-1:0]    comparator_two;
  logic [DATA_W-1:0]    preload_one;
  logic [DATA_W-1:0]    preload_two;
  logic [DATA_W-1:0]    compare_capture_control;
  logic [DATA_W-1:0]    channel_status;
  logic [IRQ_SRC_N-1:0] interrupt_request_enables;
  logic                 prev_one;
  logic                 prev_two;
  logic                 armed_one;
  logic                 armed_two;
  tcc_load_code_t       compare_load_ctl_one;
  tcc_load_code_t       compare_load_ctl_two;
  logic [1:0]           comparator_direction_sel;
  logic [1:0]           capture_edge_sel_one;
  logic [1:0]           capture_edge_sel_two;
  logic                 single_capture_sel;
  logic [1:0]           capture_fifo_watermark;
  logic                 match_one;
  logic                 match_two;
  logic                 trig_one;
  logic                 trig_two;
  logic                 overflow;
  logic                 rise_one;
  logic                 fall_one;
  logic                 hit_one;
  logic                 hit_two;
  logic [IRQ_SRC_N-1:0] events;
  logic [DATA_W-1:0]    next_rdata;

  tcc_fifo_if fifo_one ();
  tcc_fifo_if fifo_two ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_at(input logic [ADDR_W-1:0] a);
    return ce_in && wr_in && (addr_in == a);
  endfunction

  function automatic logic rd_at(input logic [ADDR_W-1:0] a);
    return ce_in && rd_in && (addr_in == a);
  endfunction

  // Code 001 is undefined and treated as no load
  function automatic logic load_trig(input logic [2:0] code,
                                     input logic m1, input logic m2);
    return (code[2] | code[1]) & (code[0] ? m2 : m1);
  endfunction

  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic cur, input logic prev);
    return (mode[1] & cur & !prev) | (mode[0] & !cur & prev);
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign compare_load_ctl_one =
    tcc_load_code_t'(compare_capture_control[COMPARE_LOAD_CTL_ONE_POS +: 3]);
  assign compare_load_ctl_two =
    tcc_load_code_t'(compare_capture_control[COMPARE_LOAD_CTL_TWO_POS +: 3]);
  assign comparator_direction_sel = compare_capture_control[CMODE_POS +: 2];
  assign capture_edge_sel_one     = compare_capture_control[CPT1_POS +: 2];
  assign capture_edge_sel_two     = compare_capture_control[CPT2_POS +: 2];
  assign single_capture_sel       = compare_capture_control[SINGLE_CAPTURE_SEL_POS];
  assign capture_fifo_watermark   = compare_capture_control[CAPTURE_FIFO_WATERMARK_POS +: 2];

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Mode bit 0 moves comparator one to down-counting, bit 1 comparator two
  assign match_one = ce_in && cnt_tick_in && (counter == comparator_one)
                     && (comparator_direction_sel[0] == cnt_down_in);
  assign match_two = ce_in && cnt_tick_in && (counter == comparator_two)
                     && (comparator_direction_sel[1] == cnt_down_in);
  assign trig_one = load_trig(compare_load_ctl_one, match_one, match_two);
  assign trig_two = load_trig(compare_load_ctl_two, match_one, match_two);
  assign overflow = ce_in && cnt_tick_in && (cnt_down_in ?
                    (counter == '0) : (counter == '1));

  // Software write wins over a preload in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      comparator_one <= WORD_RST;
    end else if (wr_at(ADDR_CMP_ONE)) begin
      comparator_one <= wdata_in;
    end else if (trig_one) begin
      case (compare_load_ctl_one[2:1])
        2'b01:   comparator_one <= preload_one;
        2'b10:   comparator_one <= preload_two;
        default: comparator_one <= comparator_one;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      comparator_two <= WORD_RST;
    end else if (wr_at(ADDR_CMP_TWO)) begin
      comparator_two <= wdata_in;
    end else if (trig_two) begin
      case (compare_load_ctl_two[2:1])
        2'b01:   comparator_two <= preload_one;
        2'b10:   comparator_two <= preload_two;
        default: comparator_two <= comparator_two;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      counter <= WORD_RST;
    end else if (wr_at(ADDR_COUNTER)) begin
      counter <= wdata_in;
    end else if ((trig_one && compare_load_ctl_one[2:1] == 2'b11) ||
                 (trig_two && compare_load_ctl_two[2:1] == 2'b11)) begin
      counter <= preload_one;
    end else if (ce_in && cnt_tick_in) begin
      counter <= cnt_down_in ? counter - 1'b1 : counter + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      preload_one <= WORD_RST;
      preload_two <= WORD_RST;
    end else begin
      if (wr_at(ADDR_PRE_ONE)) begin
        preload_one <= wdata_in;
      end
      if (wr_at(ADDR_PRE_TWO)) begin
        preload_two <= wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Pins are taken as already synchronous; a stale sample only shifts a
  // capture by one cycle.
  assign rise_one = ce_in && capture_one_in && !prev_one;
  assign fall_one = ce_in && !capture_one_in && prev_one;
  assign hit_one  = ce_in && armed_one &&
                    edge_hit(capture_edge_sel_one, capture_one_in, prev_one);
  assign hit_two  = ce_in && armed_two &&
                    edge_hit(capture_edge_sel_two, capture_two_in, prev_two);

  // A capture into a full FIFO is dropped rather than overwriting old data
  assign fifo_one.push  = hit_one && !fifo_one.full;
  assign fifo_two.push  = hit_two && !fifo_two.full;
  assign fifo_one.wdata = counter;
  assign fifo_two.wdata = counter;
  assign fifo_one.pop   = rd_at(ADDR_CAP_ONE) && !fifo_one.empty;
  assign fifo_two.pop   = rd_at(ADDR_CAP_TWO) && !fifo_two.empty;

  tcc_capture_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo_one (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .fifo       (fifo_one.store)
  );

  tcc_capture_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo_two (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .fifo       (fifo_two.store)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      prev_one <= 1'b0;
      prev_two <= 1'b0;
    end else if (ce_in) begin
      prev_one <= capture_one_in;
      prev_two <= capture_two_in;
    end
  end

  // Writing the control register re-arms a finished one-shot capture
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      armed_one <= 1'b1;
      armed_two <= 1'b1;
    end else if (wr_at(ADDR_CONTROL)) begin
      armed_one <= 1'b1;
      armed_two <= 1'b1;
    end else begin
      if (fifo_one.push && single_capture_sel) begin
        armed_one <= 1'b0;
      end
      if (fifo_two.push && single_capture_sel) begin
        armed_two <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[ST_ANY_CMP] = match_one | match_two;
    events[ST_CMP_ONE] = match_one;
    events[ST_CMP_TWO] = match_two;
    events[ST_OVF]     = overflow;
    events[ST_FALL]    = fall_one;
    events[ST_RISE]    = rise_one;
    events[ST_CAP_ONE] = fifo_one.push &&
      (fifo_one.level >= LVL_W'(capture_fifo_watermark));
    events[ST_CAP_TWO] = fifo_two.push &&
      (fifo_two.level >= LVL_W'(capture_fifo_watermark));
  end

  // A read clears the status, but an event in that cycle still sets it
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      channel_status <= WORD_RST;
    end else if (ce_in) begin
      channel_status <= (rd_at(ADDR_STATUS) ? WORD_RST : channel_status)
                        | DATA_W'(events);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      interrupt_request_enables <= IRQ_EN_RST;
      compare_capture_control   <= WORD_RST;
    end else begin
      if (wr_at(ADDR_IRQ_EN)) begin
        interrupt_request_enables <= wdata_in[IRQ_SRC_N-1:0];
      end
      if (wr_at(ADDR_CONTROL)) begin
        compare_capture_control <= {1'b0, wdata_in[DATA_W-2:0]};
      end
    end
  end

  // Registered output: follows the status one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(channel_status[IRQ_SRC_N-1:0]
                   & interrupt_request_enables);
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    case (addr_in)
      ADDR_COUNTER:  next_rdata = counter;
      ADDR_CMP_ONE:  next_rdata = comparator_one;
      ADDR_CMP_TWO:  next_rdata = comparator_two;
      ADDR_PRE_ONE:  next_rdata = preload_one;
      ADDR_PRE_TWO:  next_rdata = preload_two;
      ADDR_CAP_ONE:  next_rdata = fifo_one.empty ? '0 : fifo_one.rdata;
      ADDR_CAP_TWO:  next_rdata = fifo_two.empty ? '0 : fifo_two.rdata;
      ADDR_CONTROL:  next_rdata = compare_capture_control;
      ADDR_STATUS:   next_rdata = channel_status;
      ADDR_IRQ_EN:   next_rdata = DATA_W'(interrupt_request_enables);
      ADDR_FIFO_LVL: next_rdata = DATA_W'({fifo_two.level,
                                           fifo_one.level});
      default:       next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= WORD_RST;
    end else if (ce_in) begin
      // Holds while the clock enable is low, like every other register
      rdata_out <= rd_in ? next_rdata : WORD_RST;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  never_preload_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (compare_load_ctl_one == TCC_LD_NEVER && !wr_at(ADDR_CMP_ONE))
      |=> comparator_one == $past(comparator_one))
  else $error("Comparator one changed with load code 000");

  pre_one_load_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (compare_load_ctl_one == TCC_LD_P1_ON_C2 && match_two &&
     !wr_at(ADDR_CMP_ONE)) |=> comparator_one == $past(preload_one))
  else $error("Comparator one missed preload one on match two");

  pre_two_load_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (compare_load_ctl_one == TCC_LD_P2_ON_C1 && match_one &&
     !wr_at(ADDR_CMP_ONE)) |=> comparator_one == $past(preload_two))
  else $error("Comparator one missed preload two on match one");

  counter_load_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (compare_load_ctl_one == TCC_LD_CNT_C1 && match_one &&
     !wr_at(ADDR_COUNTER)) |=> counter == $past(preload_one))
  else $error("Counter missed preload one on match one");

  cmp_two_load_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (compare_load_ctl_two == TCC_LD_P2_ON_C2 && match_two &&
     !wr_at(ADDR_CMP_TWO)) |=> comparator_two == $past(preload_two))
  else $error("Comparator two missed preload two on match two");

  capture_off_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (capture_edge_sel_one == 2'b00 || !armed_one) |-> !fifo_one.push)
  else $error("Capture one pushed while disabled");

  counter_read_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    rd_at(ADDR_COUNTER) |=> rdata_out == $past(counter))
  else $error("Counter read returned wrong value");

  irq_follow_a :
  assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ce_in ##1 ce_in |=> irq_out ==
      |($past(channel_status[IRQ_SRC_N-1:0] & interrupt_request_enables)))
  else $error("Interrupt output does not follow enabled status");

endmodule

// ### tb_tcc_channel.sv
// Self-checking bench for the timer channel compare/capture block.
// Assumes the register map and field layout of the channel package.
`timescale 1ns/10ps
module tb_tcc_channel;
  import tcc_pkg::*;
  logic              sys_clk_in;
  logic              resetn_in;
  logic              ce_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in;
  logic              wr_in;
  logic              rd_in;
  logic [DATA_W-1:0] rdata_out;
  logic              cnt_tick_in;
  logic              cnt_down_in;
  logic              capture_one_in;
  logic              capture_two_in;
  logic              irq_out;
  int                mismatches;
  int                tests_run;
  logic [15:0]       e;

  tcc_channel dut (
    .sys_clk_in     (sys_clk_in),
    .resetn_in      (resetn_in),
    .ce_in          (ce_in),
    .addr_in        (addr_in),
    .wdata_in       (wdata_in),
    .wr_in          (wr_in),
    .rd_in          (rd_in),
    .rdata_out      (rdata_out),
    .cnt_tick_in    (cnt_tick_in),
    .cnt_down_in    (cnt_down_in),
    .capture_one_in (capture_one_in),
    .capture_two_in (capture_two_in),
    .irq_out        (irq_out)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] x,
                     input string w);
    tests_run++;
    if (got !== x) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, x);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    wr_in    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] x,
                    input string w);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    rd_in   <= 1'b0;
    #1;
    chk(rdata_out, x, w);
  endtask

  task automatic tick(input logic dn);
    @(posedge sys_clk_in);
    cnt_down_in <= dn;
    cnt_tick_in <= 1'b1;
    @(posedge sys_clk_in);
    cnt_tick_in <= 1'b0;
  endtask

  task automatic pin(input bit two, input logic v);
    @(posedge sys_clk_in);
    if (two) begin
      capture_two_in <= v;
    end else begin
      capture_one_in <= v;
    end
    @(posedge sys_clk_in);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the tests need well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    tests_run = 0;
    ce_in = 1'b1;
    resetn_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    cnt_tick_in = 1'b0;
    cnt_down_in = 1'b0;
    capture_one_in = 1'b0;
    capture_two_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd(ADDR_STATUS, 16'h0000, "status reset");
    rd(4'hb, 16'h0000, "unmapped read");
    wr(ADDR_COUNTER, 16'hffff);
    rd(ADDR_COUNTER, 16'hffff, "counter init");
    rd(ADDR_COUNTER, 16'hffff, "counter reread");
    wr(ADDR_CMP_TWO, 16'h8001);
    rd(ADDR_CMP_TWO, 16'h8001, "cmp two init");
    $display("test init done");
    // Each code tried with a match on comparator one, then on two
    wr(ADDR_PRE_ONE, 16'h1111);
    wr(ADDR_PRE_TWO, 16'h2222);
    for (int c = 0; c < 8; c++) begin
      for (int m = 0; m < 2; m++) begin
        wr(ADDR_CONTROL, 16'(c));
        wr(ADDR_CMP_ONE, 16'h0005);
        wr(ADDR_CMP_TWO, 16'h0007);
        wr(ADDR_COUNTER, m ? 16'h0007 : 16'h0005);
        tick(1'b0);
        e = (c == 2 + m) ? 16'h1111 : (c == 4 + m) ? 16'h2222 : 16'h0005;
        rd(ADDR_CMP_ONE, e, "cmp one load");
        e = (c == 6 + m) ? 16'h1111 : (m ? 16'h0008 : 16'h0006);
        rd(ADDR_COUNTER, e, "counter load");
        rd(ADDR_CMP_TWO, 16'h0007, "cmp two kept");
        rd(ADDR_STATUS, m ? 16'h0005 : 16'h0003, "match status");
      end
    end
    wr(ADDR_CONTROL, 16'h0005 << COMPARE_LOAD_CTL_TWO_POS);
    wr(ADDR_COUNTER, 16'h0007);
    tick(1'b0);
    rd(ADDR_CMP_TWO, 16'h2222, "cmp two load");
    $display("test load codes done");
    // Every direction select against both count directions
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CONTROL, 16'(i >> 1) << CMODE_POS);
      wr(ADDR_IRQ_EN, 16'h0001 << i);
      wr(ADDR_CMP_ONE, 16'h0009);
      wr(ADDR_CMP_TWO, 16'h0009);
      wr(ADDR_COUNTER, 16'h0009);
      tick(i[0]);
      e = 16'h0000;
      e[1] = (((i >> 1) & 1) == (i & 1));
      e[2] = (((i >> 2) & 1) == (i & 1));
      e[0] = e[1] | e[2];
      rd(ADDR_STATUS, e, "direction status");
      chk(16'(irq_out), 16'(|(e[7:0] & (8'h01 << i))), "irq");
    end
    $display("test direction done");
    wr(ADDR_IRQ_EN, 16'h0040);
    wr(ADDR_COUNTER, 16'h1234);
    for (int md = 0; md < 4; md++) begin
      wr(ADDR_CONTROL, 16'(md) << CPT1_POS);
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
      e = (md == 3) ? 16'h0002 : (md == 0) ? 16'h0000 : 16'h0001;
      rd(ADDR_FIFO_LVL, e, "capture level");
      rd(ADDR_STATUS, (e != 0) ? 16'h0070 : 16'h0030, "edge st");
      chk(16'(irq_out), 16'(e != 0), "capture irq");
      for (int k = 0; k < e; k++) begin
        rd(ADDR_CAP_ONE, 16'h1234, "capture word");
      end
    end
    $display("test capture modes done");
    wr(ADDR_CONTROL, (16'h0003 << CAPTURE_FIFO_WATERMARK_POS) | (16'h0003 << CPT2_POS));
    for (int k = 0; k < 10; k++) begin
      pin(1'b1, ~capture_two_in);
      if (k == 2) begin
        rd(ADDR_STATUS, 16'h0000, "below watermark");
      end
      if (k == 3) begin
        rd(ADDR_STATUS, 16'h0080, "at watermark");
      end
    end
    // Pushes beyond eight are dropped, so the level saturates
    rd(ADDR_FIFO_LVL, 16'h0080, "full level");
    for (int k = 0; k < 8; k++) begin
      rd(ADDR_CAP_TWO, 16'h1234, "drain word");
    end
    rd(ADDR_CAP_TWO, 16'h0000, "empty pop");
    rd(ADDR_FIFO_LVL, 16'h0000, "empty level");
    $display("test fifo done");
    wr(ADDR_CONTROL, (16'h0001 << SINGLE_CAPTURE_SEL_POS) | (16'h0002 << CPT1_POS));
    repeat (2) begin
      pin(1'b0, 1'b1);
      pin(1'b0, 1'b0);
    end
    rd(ADDR_FIFO_LVL, 16'h0001, "one shot");
    $display("test one shot done");
    // Sticky bits left by the capture tests: both edges, both captures
    rd(ADDR_STATUS, 16'h00f0, "capture status");
    wr(ADDR_IRQ_EN, 16'h0008);
    wr(ADDR_COUNTER, 16'hffff);
    // A tick with the clock enable low must leave the counter alone
    ce_in <= 1'b0;
    tick(1'b0);
    ce_in <= 1'b1;
    rd(ADDR_COUNTER, 16'hffff, "frozen counter");
    tick(1'b0);
    rd(ADDR_COUNTER, 16'h0000, "wrapped counter");
    rd(ADDR_STATUS, 16'h0008, "overflow status");
    chk(16'(irq_out), 16'h0001, "overflow irq");
    $display("test overflow done");
    conclude();
  end
endmodule
